/* File: hdl/prescaler_pkg.sv */
package prescaler_pkg;

	// Register map of the block, 8-bit registers on a 4-bit word address.
	localparam int ADDR_WIDTH = 4;
	localparam int DATA_WIDTH = 8;
	localparam logic [3:0] ADDR_SYNC_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_COUNT_LOW    = 4'h1;
	localparam logic [3:0] ADDR_COUNT_HIGH   = 4'h2;
	localparam logic [3:0] ADDR_PIN_STATUS   = 4'h3;

	// Field positions inside timer_sync_control.
	localparam int SYNC_HOLD_BIT    = 7;
	localparam int ASYNC_RESET_BIT  = 1;
	localparam int SHARED_RESET_BIT = 0;
	localparam logic [7:0] SYNC_CONTROL_RESET = 8'h00;

	// Shared prescaler counter and its tap masks.
	localparam int PRESCALE_WIDTH = 10;
	localparam logic [9:0] PRESCALE_RESET = 10'h000;
	localparam logic [9:0] TAP_MASK_DIV8    = 10'h007;
	localparam logic [9:0] TAP_MASK_DIV64   = 10'h03F;
	localparam logic [9:0] TAP_MASK_DIV256  = 10'h0FF;
	localparam logic [9:0] TAP_MASK_DIV1024 = 10'h3FF;
	localparam int TAP_COUNT = 4;

	// Worst wait for the first prescaled tick after enabling a source.
	localparam int FIRST_TICK_DIV8_MAX = 8;

	// Clock source select codes in their natural order 0 to 7.
	typedef enum logic [2:0] {
		SOURCE_STOP,
		SOURCE_DIRECT,
		SOURCE_DIV8,
		SOURCE_DIV64,
		SOURCE_DIV256,
		SOURCE_DIV1024,
		SOURCE_EXT_FALL,
		SOURCE_EXT_RISE
	} clock_source_type;

endpackage

/* File: hdl/pin_edge_sync.sv */
module pin_edge_sync (
	input  wire logic clk,  // system I/O clock
	input  wire logic rst,  // synchronous reset, active high
	input  wire logic ce,   // clock enable, freezes the flops while low
	input  wire logic pin,  // external count pin
	output logic      level, // synchronized pin level
	output logic      rise, // rising edge seen, one cycle
	output logic      fall  // falling edge seen, one cycle
);

	logic latch_q;
	logic first_q;
	logic prev_q;

	// Latch is open during the high phase of the clock.
	always_latch begin
		if (clk) begin
			latch_q = pin;
		end
	end

	// The first flop feeds only the second; edges are taken between the second and third.
	always_ff @(posedge clk) begin
		if (rst) begin
			first_q <= 1'b0;
			level   <= 1'b0;
			prev_q  <= 1'b0;
		end else if (ce) begin
			first_q <= latch_q;
			level   <= first_q;
			prev_q  <= level;
		end
	end

	assign rise = level & ~prev_q;
	assign fall = ~level & prev_q;

endmodule

/* File: hdl/tick_select.sv */
module tick_select (
	input  wire logic       ce,        // clock enable
	input  wire logic [2:0] sel,       // clock_source_select of one timer
	input  wire logic [3:0] tap,       // prescaler tap pulses /8 /64 /256 /1024
	input  wire logic       rise,      // synchronized rising edge of count pin
	input  wire logic       fall,      // synchronized falling edge of count pin
	output logic            tick       // timer_tick pulse to the timer
);

	prescaler_pkg::clock_source_type source;
	logic                            raw;

	assign source = prescaler_pkg::clock_source_type'(sel);

	always_comb begin
		case (source)
			prescaler_pkg::SOURCE_STOP:     raw = 1'b0;
			prescaler_pkg::SOURCE_DIRECT:   raw = 1'b1;
			prescaler_pkg::SOURCE_DIV8:     raw = tap[0];
			prescaler_pkg::SOURCE_DIV64:    raw = tap[1];
			prescaler_pkg::SOURCE_DIV256:   raw = tap[2];
			prescaler_pkg::SOURCE_DIV1024:  raw = tap[3];
			prescaler_pkg::SOURCE_EXT_FALL: raw = fall;
			prescaler_pkg::SOURCE_EXT_RISE: raw = rise;
			default:                        raw = 1'b0;
		endcase
	end

	assign tick = ce & raw;

endmodule

/* File: hdl/shared_timer_prescaler.sv */
// Overview of operation
// - Select code one ticks the timer on every enabled system clock cycle.
// - Select codes two to five tick the timer from the /8, /64, /256 and /1024 taps.
// - One free-running prescaler serves all three timers, each choosing its own tap.
// - Because the prescaler runs free, a first prescaled tick comes 1 to N cycles later.
// - A prescaler reset restarts the tap phase for all three timers together.
// - Each count pin is sampled every cycle and the sampled level feeds an edge detector.
// - The sampler is a latch open while clk is high followed by rising-edge flops.
// - Select code seven ticks on pin rising edges and six on falling edges.
// - A pin edge reaches the counter update 2.5 to 3.5 system clock cycles later.
// - Pin edges drive the timer directly and never pass the prescaler taps.
// - In sync hold mode both prescaler reset bits keep their written value.
// - Writing sync hold mode to zero clears both reset bits so the timers start together.
// - Writing one to the shared reset bit resets the prescaler and clears unless held.
module shared_timer_prescaler (
	input  wire logic       clk,          // system I/O clock, 25 MHz
	input  wire logic       rst,          // synchronous reset, active high
	input  wire logic       ce,           // clock enable, freezes all flops while low
	input  wire logic [3:0] addr,         // register address
	input  wire logic [7:0] wdata,        // register write data
	input  wire logic       wr,           // write strobe
	input  wire logic       rd,           // read strobe
	output logic      [7:0] rdata,        // read data, valid the cycle after rd
	input  wire logic [2:0] select0,      // clock_source_select of timer 0
	input  wire logic [2:0] select1,      // clock_source_select of timer 1
	input  wire logic [2:0] select2,      // clock_source_select of timer 2
	input  wire logic       count_pin0,   // external_count_pin of timer 0
	input  wire logic       count_pin1,   // external_count_pin of timer 1
	input  wire logic       count_pin2,   // external_count_pin of timer 2
	output logic            timer_tick0,  // count pulse to timer 0
	output logic            timer_tick1,  // count pulse to timer 1
	output logic            timer_tick2,  // count pulse to timer 2
	output logic            async_reset   // async_prescaler_reset to the async timer
);

	logic       sync_hold_mode;
	logic       async_prescaler_reset;
	logic       shared_prescaler_reset;
	logic [9:0] prescale;
	logic [9:0] next_prescale;
	logic [3:0] tap;
	logic [2:0] level;
	logic [2:0] rise;
	logic [2:0] fall;
	logic [7:0] next_rdata;

	wire write_en = wr & ce;
	wire read_en  = rd & ce;
	wire hit_control = addr == prescaler_pkg::ADDR_SYNC_CONTROL;
	wire hit_low     = addr == prescaler_pkg::ADDR_COUNT_LOW;
	wire hit_high    = addr == prescaler_pkg::ADDR_COUNT_HIGH;
	wire hit_pins    = addr == prescaler_pkg::ADDR_PIN_STATUS;
	wire control_write = write_en & hit_control;
	wire hold_bit   = wdata[prescaler_pkg::SYNC_HOLD_BIT];
	wire async_bit  = wdata[prescaler_pkg::ASYNC_RESET_BIT];
	wire shared_bit = wdata[prescaler_pkg::SHARED_RESET_BIT];

	wire [7:0] control_view = {sync_hold_mode, 5'h00, async_prescaler_reset,
		shared_prescaler_reset};

	// Prescaler advances every enabled cycle and is held at zero in reset.
	assign next_prescale = shared_prescaler_reset ? prescaler_pkg::PRESCALE_RESET
		: prescale + 10'h001;

	// A tap fires on the last count of its period; none fires while reset is held.
	assign tap[0] = ~shared_prescaler_reset
		& ((prescale & prescaler_pkg::TAP_MASK_DIV8) == prescaler_pkg::TAP_MASK_DIV8);
	assign tap[1] = ~shared_prescaler_reset
		& ((prescale & prescaler_pkg::TAP_MASK_DIV64) == prescaler_pkg::TAP_MASK_DIV64);
	assign tap[2] = ~shared_prescaler_reset
		& ((prescale & prescaler_pkg::TAP_MASK_DIV256) == prescaler_pkg::TAP_MASK_DIV256);
	assign tap[3] = ~shared_prescaler_reset
		& ((prescale & prescaler_pkg::TAP_MASK_DIV1024) == prescaler_pkg::TAP_MASK_DIV1024);

	assign next_rdata = ~read_en ? 8'h00
		: hit_control ? control_view
		: hit_low ? prescale[7:0]
		: hit_high ? {6'h00, prescale[9:8]}
		: hit_pins ? {5'h00, level}
		: 8'h00;

	assign async_reset = async_prescaler_reset;

	always_ff @(posedge clk) begin
		if (rst) begin
			prescale <= prescaler_pkg::PRESCALE_RESET;
		end else if (ce) begin
			prescale <= next_prescale;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sync_hold_mode <= prescaler_pkg::SYNC_CONTROL_RESET[prescaler_pkg::SYNC_HOLD_BIT];
		end else if (control_write) begin
			sync_hold_mode <= hold_bit;
		end
	end

	// Reset bits take the written value; without hold mode they clear one cycle later.
	always_ff @(posedge clk) begin
		if (rst) begin
			shared_prescaler_reset <=
				prescaler_pkg::SYNC_CONTROL_RESET[prescaler_pkg::SHARED_RESET_BIT];
			async_prescaler_reset <=
				prescaler_pkg::SYNC_CONTROL_RESET[prescaler_pkg::ASYNC_RESET_BIT];
		end else if (control_write) begin
			shared_prescaler_reset <= shared_bit;
			async_prescaler_reset  <= async_bit;
		end else if (ce && !sync_hold_mode) begin
			shared_prescaler_reset <= 1'b0;
			async_prescaler_reset  <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata <= 8'h00;
		end else if (ce) begin
			rdata <= next_rdata;
		end
	end

	pin_edge_sync sync0 (
		.clk   (clk),
		.rst   (rst),
		.ce    (ce),
		.pin   (count_pin0),
		.level (level[0]),
		.rise  (rise[0]),
		.fall  (fall[0])
	);

	pin_edge_sync sync1 (
		.clk   (clk),
		.rst   (rst),
		.ce    (ce),
		.pin   (count_pin1),
		.level (level[1]),
		.rise  (rise[1]),
		.fall  (fall[1])
	);

	pin_edge_sync sync2 (
		.clk   (clk),
		.rst   (rst),
		.ce    (ce),
		.pin   (count_pin2),
		.level (level[2]),
		.rise  (rise[2]),
		.fall  (fall[2])
	);

	// All three selectors read the same tap vector.
	tick_select select_t0 (
		.ce   (ce),
		.sel  (select0),
		.tap  (tap),
		.rise (rise[0]),
		.fall (fall[0]),
		.tick (timer_tick0)
	);

	tick_select select_t1 (
		.ce   (ce),
		.sel  (select1),
		.tap  (tap),
		.rise (rise[1]),
		.fall (fall[1]),
		.tick (timer_tick1)
	);

	tick_select select_t2 (
		.ce   (ce),
		.sel  (select2),
		.tap  (tap),
		.rise (rise[2]),
		.fall (fall[2]),
		.tick (timer_tick2)
	);

	localparam int FIRST_MAX = prescaler_pkg::FIRST_TICK_DIV8_MAX;

	property p_direct_tick;
		@(posedge clk) disable iff (rst)
		(ce && select1 == 3'h1) |-> timer_tick1;
	endproperty
	a_direct_tick: assert property (p_direct_tick)
		else $error("direct source did not tick every cycle");

	property p_div8_period;
		@(posedge clk) disable iff (rst)
		(ce && select0 == 3'h2 && timer_tick0)
			##1 (ce && select0 == 3'h2 && !shared_prescaler_reset)[*7]
			|-> ##1 (timer_tick0 || !ce || shared_prescaler_reset);
	endproperty
	a_div8_period: assert property (p_div8_period)
		else $error("divide by eight tap period wrong");

	property p_div8_quiet;
		@(posedge clk) disable iff (rst)
		(select0 == 3'h2 && timer_tick0) |=> !timer_tick0;
	endproperty
	a_div8_quiet: assert property (p_div8_quiet)
		else $error("divide by eight tap fired twice in a row");

	property p_free_running;
		@(posedge clk) disable iff (rst)
		(ce && !shared_prescaler_reset) |=> prescale == $past(prescale) + 10'h001;
	endproperty
	a_free_running: assert property (p_free_running)
		else $error("prescaler did not advance");

	property p_shared_taps;
		@(posedge clk) disable iff (rst)
		(select0 == 3'h2 && select1 == 3'h3 && timer_tick1) |-> timer_tick0;
	endproperty
	a_shared_taps: assert property (p_shared_taps)
		else $error("divide by sixty-four tick not aligned with divide by eight tick");

	property p_first_tick;
		@(posedge clk) disable iff (rst)
		(select0 == 3'h2 && $past(select0) == 3'h0)
			|-> ##[0:FIRST_MAX] (timer_tick0 || !ce || shared_prescaler_reset);
	endproperty
	a_first_tick: assert property (p_first_tick)
		else $error("first prescaled tick came too late");

	property p_reset_restarts;
		@(posedge clk) disable iff (rst)
		(ce && shared_prescaler_reset) |=> prescale == 10'h000
			&& (!timer_tick1 || select1 == 3'h1 || select1 >= 3'h6);
	endproperty
	a_reset_restarts: assert property (p_reset_restarts)
		else $error("prescaler reset did not restart the phase");

	sequence s_rise_seen;
		$rose(count_pin0) && ce && select0 == 3'h7;
	endsequence

	property p_rise_latency;
		@(posedge clk) disable iff (rst)
		s_rise_seen ##1 (ce && select0 == 3'h7)[*2] |-> timer_tick0;
	endproperty
	a_rise_latency: assert property (p_rise_latency)
		else $error("rising pin edge not counted in time");

	sequence s_fall_seen;
		$fell(count_pin1) && ce && select1 == 3'h6;
	endsequence

	property p_fall_latency;
		@(posedge clk) disable iff (rst)
		s_fall_seen ##1 (ce && select1 == 3'h6)[*2] |-> timer_tick1;
	endproperty
	a_fall_latency: assert property (p_fall_latency)
		else $error("falling pin edge not counted in time");

	property p_external_no_tap;
		@(posedge clk) disable iff (rst)
		(select0 == 3'h7 && !rise[0]) |-> !timer_tick0;
	endproperty
	a_external_no_tap: assert property (p_external_no_tap)
		else $error("external source ticked without an edge");

	property p_hold_keeps;
		@(posedge clk) disable iff (rst)
		(sync_hold_mode && !control_write) |=> $stable(shared_prescaler_reset)
			&& $stable(async_prescaler_reset);
	endproperty
	a_hold_keeps: assert property (p_hold_keeps)
		else $error("reset bits changed in hold mode");

	property p_release_together;
		@(posedge clk) disable iff (rst)
		(control_write && !hold_bit) ##1 (ce && !control_write)
			|=> !shared_prescaler_reset && !async_prescaler_reset && !sync_hold_mode;
	endproperty
	a_release_together: assert property (p_release_together)
		else $error("hold release did not clear reset bits");

	sequence s_one_shot;
		shared_prescaler_reset ##1 !shared_prescaler_reset;
	endsequence

	property p_self_clear;
		@(posedge clk) disable iff (rst)
		(control_write && !hold_bit && shared_bit) ##1 (ce && !control_write)
			|-> s_one_shot;
	endproperty
	a_self_clear: assert property (p_self_clear)
		else $error("shared reset bit did not self clear");

	property p_stopped;
		@(posedge clk) disable iff (rst)
		(select2 == 3'h0) |-> !timer_tick2;
	endproperty
	a_stopped: assert property (p_stopped)
		else $error("stopped timer received a tick");

endmodule

/* File: dv/timer_model.sv */
module timer_model (
	input  wire logic        clk,    // system clock
	input  wire logic        rst,    // synchronous reset, active high
	input  wire logic        tick0,  // count pulse of timer 0
	input  wire logic        tick1,  // count pulse of timer 1
	input  wire logic        tick2,  // count pulse of timer 2
	output logic      [31:0] count0, // counts taken by timer 0
	output logic      [31:0] count1, // counts taken by timer 1
	output logic      [31:0] count2  // counts taken by timer 2
);
	timeunit 1ns;
	timeprecision 1ps;

	// Each timer advances once for every tick sampled high, as a real counter would.
	always_ff @(posedge clk) begin
		if (rst) begin
			count0 <= 32'h0;
			count1 <= 32'h0;
			count2 <= 32'h0;
		end else begin
			count0 <= count0 + {31'h0, tick0};
			count1 <= count1 + {31'h0, tick1};
			count2 <= count2 + {31'h0, tick2};
		end
	end
endmodule

/* File: dv/shared_timer_prescaler_test.sv */
module shared_timer_prescaler_test;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int LIMIT = 20000;
	logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0, pins = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [7:0]  wdata = 8'h00;
	logic [2:0]  select0 = 3'h0, select1 = 3'h0, select2 = 3'h0;
	logic [7:0]  rdata;
	logic        timer_tick0, timer_tick1, timer_tick2, async_reset;
	logic [31:0] count0, count1, count2, c0, c1, c2, t1, t2, cyc = 32'h0;
	logic        rd_q = 1'b0, ext_on = 1'b0;
	logic [31:0] q0[$], q1[$], qr[$];
	int          err_total = 0, checks = 0;

	always #20 clk = ~clk;

	shared_timer_prescaler shared_timer_prescaler_inst (
		.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .select0(select0), .select1(select1), .select2(select2),
		.count_pin0(pins), .count_pin1(pins), .count_pin2(pins),
		.timer_tick0(timer_tick0), .timer_tick1(timer_tick1), .timer_tick2(timer_tick2),
		.async_reset(async_reset)
	);

	timer_model timer_model_inst (
		.clk(clk), .rst(rst), .tick0(timer_tick0), .tick1(timer_tick1), .tick2(timer_tick2),
		.count0(count0), .count1(count1), .count2(count2)
	);

	task automatic end_of_test();
		if (err_total == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// The expected read value is queued here and compared when the data stand.
	task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		qr.push_back({24'h0, exp});
		@(posedge clk);
		rd <= 1'b0;
	endtask

	task automatic wait_tick(input bit second, output logic [31:0] at);
		at = 32'hFFFFFFFF;
		for (int i = 0; i < 2000; i++) begin
			@(posedge clk);
			if ((second ? timer_tick1 : timer_tick0) === 1'b1) begin
				at = cyc;
				break;
			end
		end
	endtask

	// Any 2048-cycle span holds a whole number of periods of every tap.
	task automatic window(input logic [2:0] s0, s1, s2, input logic [31:0] e0, e1, e2);
		@(posedge clk);
		select0 <= s0;
		select1 <= s1;
		select2 <= s2;
		repeat (2) @(posedge clk);
		c0 = count0;
		c1 = count1;
		c2 = count2;
		repeat (2048) @(posedge clk);
		chk(count0 - c0, e0);
		chk(count1 - c1, e1);
		chk(count2 - c2, e2);
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 32'h1;
		rd_q <= rd;
		if (rd_q) chk({24'h0, rdata}, qr.pop_front());
		if (ext_on && timer_tick0 === 1'b1) chk(cyc, q0.size() ? q0.pop_front() : 32'hFFFFFFFF);
		if (ext_on && timer_tick1 === 1'b1) chk(cyc, q1.size() ? q1.pop_front() : 32'hFFFFFFFF);
		if (cyc == LIMIT) begin
			err_total++;
			end_of_test();
		end
	end

	initial begin
		void'($urandom(32'h1da9));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd_reg(prescaler_pkg::ADDR_SYNC_CONTROL, prescaler_pkg::SYNC_CONTROL_RESET);
		rd_reg(4'h7, 8'h00);
		chk({31'h0, async_reset}, 32'h0);
		ce <= 1'b0;
		wr_reg(prescaler_pkg::ADDR_SYNC_CONTROL, 8'h81);
		ce <= 1'b1;
		rd_reg(prescaler_pkg::ADDR_SYNC_CONTROL, 8'h00);
		pins <= 1'b1;
		repeat (4) @(posedge clk);
		rd_reg(prescaler_pkg::ADDR_PIN_STATUS, 8'h07);
		pins <= 1'b0;
		repeat ($urandom_range(20, 1)) @(posedge clk);
		select0 <= prescaler_pkg::SOURCE_DIV8;
		t1 = cyc;
		wait_tick(1'b0, t2);
		chk({31'h0, (t2 - t1 >= 32'h1) && (t2 - t1 <= 32'h9)}, 32'h1);
		select1 <= prescaler_pkg::SOURCE_DIV64;
		wr_reg(prescaler_pkg::ADDR_SYNC_CONTROL, 8'h01);
		wait_tick(1'b0, t1);
		wait_tick(1'b1, t2);
		chk(t2 - t1, 32'h38);
		rd_reg(prescaler_pkg::ADDR_SYNC_CONTROL, 8'h00);
		window(prescaler_pkg::SOURCE_DIV8, prescaler_pkg::SOURCE_DIV64,
			prescaler_pkg::SOURCE_DIV256, 32'h100, 32'h20, 32'h8);
		window(prescaler_pkg::SOURCE_DIV1024, prescaler_pkg::SOURCE_DIRECT,
			prescaler_pkg::SOURCE_STOP, 32'h2, 32'h800, 32'h0);
		wr_reg(prescaler_pkg::ADDR_SYNC_CONTROL, {1'b1, 5'($urandom), 2'b11});
		repeat (3) @(posedge clk);
		rd_reg(prescaler_pkg::ADDR_SYNC_CONTROL, 8'h83);
		chk({31'h0, async_reset}, 32'h1);
		window(prescaler_pkg::SOURCE_DIV8, prescaler_pkg::SOURCE_DIV256,
			prescaler_pkg::SOURCE_STOP, 32'h0, 32'h0, 32'h0);
		wr_reg(prescaler_pkg::ADDR_SYNC_CONTROL, 8'h03);
		rd_reg(prescaler_pkg::ADDR_SYNC_CONTROL, 8'h00);
		chk({31'h0, async_reset}, 32'h0);
		// Once released, the prescaler has advanced twice when the next read is taken.
		rd_reg(prescaler_pkg::ADDR_COUNT_LOW, 8'h02);
		rd_reg(prescaler_pkg::ADDR_COUNT_HIGH, 8'h00);
		// The pins have been low for many cycles before the edge sources are chosen.
		select0 <= prescaler_pkg::SOURCE_EXT_RISE;
		select1 <= prescaler_pkg::SOURCE_EXT_FALL;
		@(posedge clk);
		ext_on <= 1'b1;
		repeat (20) begin
			repeat ($urandom_range(4, 2)) @(posedge clk);
			if (pins) q1.push_back(cyc + 32'h3);
			else q0.push_back(cyc + 32'h3);
			pins <= ~pins;
		end
		repeat (6) @(posedge clk);
		chk(32'(q0.size() + q1.size()), 32'h0);
		ext_on <= 1'b0;
		end_of_test();
	end
endmodule
